// file: companion_host.sv
// companion controller model driving the apb register port
module companion_host (
	// apb
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
	end

	// one transfer, entered just after a rising edge, returns after one idle edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		pwdata  <= ~d;
		@(posedge pclk);
	endtask
endmodule

// file: digital_gain_stage.sv
// continuous digital gain stage, re-evaluated every two bit periods
module digital_gain_stage (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// control
	input  wire logic       enable,
	input  wire logic       bit_tick,
	input  wire logic [7:0] level,
	// result
	output logic [3:0]      digital_gain
);
	import gain_control_pkg::*;

	typedef struct packed {
		logic [1:0] bits;
		logic [3:0] gain;
	} dgs_s;

	dgs_s state_reg;
	dgs_s state_next;

	always_comb begin
		state_next = state_reg;
		if (!enable) begin
			state_next.bits = 2'h0;
		end else if (bit_tick) begin
			if (state_reg.bits == 2'(digital_gain_stage_bit_periods - 1)) begin
				state_next.bits = 2'h0;
				if (level < 8'h60 && state_reg.gain != 4'hf)
					state_next.gain = state_reg.gain + 4'h1;
				else if (level > 8'ha0 && state_reg.gain != 4'h0)
					state_next.gain = state_reg.gain - 4'h1;
			end else begin
				state_next.bits = state_reg.bits + 2'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state_reg <= '{bits: 2'h0, gain: 4'h8};
		else
			state_reg <= state_next;
	end

	assign digital_gain = state_reg.gain;

endmodule

// file: gain_control_pkg.sv
// constants, register map and types of the receiver gain control block
package gain_control_pkg;

	// ----------------------------------------
	// register byte addresses
	// ----------------------------------------
	localparam logic [7:0] front_gain_control_off = 8'h00;
	localparam logic [7:0] strength_threshold_off = 8'h04;
	localparam logic [7:0] receive_control_off    = 8'h08;
	localparam logic [7:0] gain_level_thr_off     = 8'h0c;
	localparam logic [7:0] digital_gain_test_off  = 8'h10;
	localparam logic [7:0] bandwidth_off          = 8'h14;
	localparam logic [7:0] status_off             = 8'h18;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int impedance_bit      = 7;
	localparam int applied_lsb        = 3;
	localparam int restart_bit_pos    = 2;
	localparam int auto_restart_pos   = 1;
	localparam int packet_mode_pos    = 0;
	localparam int rx_enable_pos      = 3;
	localparam int afc_auto_pos       = 4;
	localparam int low_beta_pos       = 5;
	localparam int delay_lsb          = 8;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0]  front_gain_reset   = 8'h08;
	localparam logic [7:0]  threshold_reset    = 8'he4;
	localparam logic [15:0] control_reset      = 16'h0001;
	localparam logic [39:0] level_thr_reset    = 40'h50_60_70_80_90;
	localparam logic [7:0]  digital_gain_stage_test_reset    = 8'h30;
	localparam logic [7:0]  digital_gain_stage_enable_low    = 8'h20;
	localparam logic [7:0]  digital_gain_stage_enable_normal = 8'h30;
	localparam logic [15:0] bandwidth_reset    = 16'h8b55;

	// ----------------------------------------
	// reference level constants, dB and dBm
	// ----------------------------------------
	localparam int thermal_floor_dbm    = -174;
	localparam int noise_figure_db      = 7;
	localparam int demod_snr_constant   = 8;
	localparam int fade_margin_constant = 5;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int qualify_samples   = 2;
	localparam int digital_gain_stage_bit_periods  = 2;
	localparam int delay_unit_bits   = 16;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {st_idle, st_wait, st_hold, st_delay} gain_state_e;

endpackage

// file: receiver_gain_control.sv
// receiver analog and digital gain control with apb register file
module receiver_gain_control (
	// apb
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// receiver datapath, from pins
	input  wire logic        adc_i_bit,
	input  wire logic        adc_q_bit,
	input  wire logic        bit_tick,
	input  wire logic        fifo_empty,
	input  wire logic        packet_done,
	// analog and digital gain controls, reference level
	output logic [2:0]       applied_gain_step,
	output logic             input_impedance_select,
	output logic [7:0]       active_bandwidth,
	output logic [3:0]       digital_gain,
	output logic [8:0]       reference_level_dbm
);
	import gain_control_pkg::*;

	typedef struct packed {
		logic [1:0]  sync_i;
		logic [1:0]  sync_q;
		logic [1:0]  sync_tick;
		logic [1:0]  sync_empty;
		logic [1:0]  sync_done;
		logic [4:0]  acc_i;
		logic [4:0]  acc_q;
		logic [3:0]  dec_cnt;
		logic [7:0]  signal_strength_value;
		logic [7:0]  front_gain_control_reg;
		logic [7:0]  strength_threshold_reg;
		logic [15:0] control_reg;
		logic [39:0] level_thr_reg;
		logic [7:0]  digital_gain_test_reg;
		logic [15:0] bandwidth_reg;
		gain_state_e fsm;
		logic [1:0]  qual_cnt;
		logic [11:0] delay_cnt;
		logic        acquiring;
		logic [2:0]  gain;
		logic        tick_d;
		logic [31:0] rdata;
		logic        ready;
		logic        err;
	} rgc_s;

	rgc_s r_reg;
	rgc_s r_next;

	logic        tick_pulse;
	logic        digital_gain_stage_on;
	logic [2:0]  auto_step;
	logic [7:0]  cur_bw;
	logic        access;
	logic        restart_req;
	logic [8:0]  log_term;
	logic [8:0]  ref_level;

	// ----------------------------------------
	// decode gain step from level, five thresholds
	// ----------------------------------------
	always_comb begin
		auto_step = 3'h1;
		if (r_reg.signal_strength_value < r_reg.level_thr_reg[39:32])
			auto_step = 3'h1;
		else if (r_reg.signal_strength_value < r_reg.level_thr_reg[31:24])
			auto_step = 3'h2;
		else if (r_reg.signal_strength_value < r_reg.level_thr_reg[23:16])
			auto_step = 3'h3;
		else if (r_reg.signal_strength_value < r_reg.level_thr_reg[15:8])
			auto_step = 3'h4;
		else if (r_reg.signal_strength_value < r_reg.level_thr_reg[7:0])
			auto_step = 3'h5;
		else
			auto_step = 3'h6;
	end

	// ----------------------------------------
	// reference level: log term about 10log(2bw) in dB
	// ----------------------------------------
	always_comb begin
		log_term = 9'(40 + 3 * (7 - int'(r_reg.bandwidth_reg[2:0])));
		ref_level = 9'(thermal_floor_dbm + noise_figure_db + demod_snr_constant
			+ fade_margin_constant) + log_term;
	end

	assign tick_pulse  = r_reg.sync_tick[1] & ~r_reg.tick_d;
	assign digital_gain_stage_on     = r_reg.digital_gain_test_reg == digital_gain_stage_enable_low
		|| r_reg.digital_gain_test_reg == digital_gain_stage_enable_normal;
	assign access      = psel & penable & ~r_reg.ready;
	assign restart_req = access & pwrite & paddr == receive_control_off & pwdata[restart_bit_pos];
	assign cur_bw      = (r_reg.control_reg[afc_auto_pos] && r_reg.acquiring) ?
		r_reg.bandwidth_reg[15:8] : r_reg.bandwidth_reg[7:0];

	// ----------------------------------------
	// main next state
	// ----------------------------------------
	always_comb begin
		r_next = r_reg;
		r_next.sync_i     = {r_reg.sync_i[0], adc_i_bit};
		r_next.sync_q     = {r_reg.sync_q[0], adc_q_bit};
		r_next.sync_tick  = {r_reg.sync_tick[0], bit_tick};
		r_next.sync_empty = {r_reg.sync_empty[0], fifo_empty};
		r_next.sync_done  = {r_reg.sync_done[0], packet_done};
		r_next.tick_d     = r_reg.sync_tick[1];

		// one-bit streams decimated by 16, magnitude in half dB steps
		r_next.dec_cnt = r_reg.dec_cnt + 4'h1;
		r_next.acc_i = r_reg.acc_i + {4'h0, r_reg.sync_i[1]};
		r_next.acc_q = r_reg.acc_q + {4'h0, r_reg.sync_q[1]};
		if (r_reg.dec_cnt == 4'hf) begin
			r_next.signal_strength_value = 8'({r_reg.acc_i, 3'h0}) + 8'({r_reg.acc_q, 3'h0});
			r_next.acc_i = 5'h0;
			r_next.acc_q = 5'h0;
		end

		// gain acquisition state machine
		unique case (r_reg.fsm)
			st_idle: begin
				if (r_reg.control_reg[rx_enable_pos]) begin
					r_next.fsm = st_wait;
					r_next.acquiring = 1'b1;
					r_next.qual_cnt = 2'h0;
				end
			end
			st_wait: begin
				if (tick_pulse) begin
					if (r_reg.signal_strength_value > r_reg.strength_threshold_reg) begin
						r_next.qual_cnt = r_reg.qual_cnt + 2'h1;
						if (r_reg.qual_cnt == 2'(qualify_samples - 1)) begin
							r_next.fsm = st_hold;
							r_next.gain = auto_step;
							r_next.acquiring = 1'b0;
						end
					end else begin
						r_next.qual_cnt = 2'h0;
					end
				end
			end
			st_hold: begin
				// continuous mode and no auto restart keep gain here
				if (r_reg.control_reg[packet_mode_pos] && r_reg.control_reg[auto_restart_pos]
					&& r_reg.sync_done[1] && r_reg.sync_empty[1]) begin
					r_next.fsm = st_delay;
					r_next.delay_cnt = 12'({r_reg.control_reg[15:delay_lsb], 4'h0});
				end
			end
			st_delay: begin
				if (r_reg.delay_cnt == 12'h0) begin
					r_next.fsm = st_wait;
					r_next.acquiring = 1'b1;
					r_next.qual_cnt = 2'h0;
				end else if (tick_pulse) begin
					r_next.delay_cnt = r_reg.delay_cnt - 12'h1;
				end
			end
		endcase
		if (restart_req && r_reg.control_reg[rx_enable_pos]) begin
			r_next.fsm = st_wait;
			r_next.acquiring = 1'b1;
			r_next.qual_cnt = 2'h0;
		end
		if (!r_reg.control_reg[rx_enable_pos]) begin
			r_next.fsm = st_idle;
			r_next.acquiring = 1'b0;
		end

		// applied step: fixed selection or loop result
		if (r_reg.front_gain_control_reg[2:0] != 3'h0 && r_reg.front_gain_control_reg[2:0] != 3'h7)
			r_next.front_gain_control_reg[5:applied_lsb] = r_reg.front_gain_control_reg[2:0];
		else if (r_reg.front_gain_control_reg[2:0] == 3'h0)
			r_next.front_gain_control_reg[5:applied_lsb] = r_reg.gain;

		// apb slave, one wait state
		r_next.ready = access;
		r_next.err = 1'b0;
		if (access) begin
			r_next.rdata = 32'h0;
			unique case (paddr)
				front_gain_control_off: begin
					r_next.rdata = {24'h0, r_reg.front_gain_control_reg};
					if (pwrite) begin
						r_next.front_gain_control_reg[impedance_bit] = pwdata[impedance_bit];
						r_next.front_gain_control_reg[2:0] = pwdata[2:0];
					end
				end
				strength_threshold_off: begin
					r_next.rdata = {24'h0, r_reg.strength_threshold_reg};
					if (pwrite)
						r_next.strength_threshold_reg = pwdata[7:0];
				end
				receive_control_off: begin
					r_next.rdata = {16'h0, r_reg.control_reg & ~16'(1 << restart_bit_pos)};
					if (pwrite)
						r_next.control_reg = pwdata[15:0] & ~16'(1 << restart_bit_pos);
				end
				gain_level_thr_off: begin
					r_next.rdata = r_reg.level_thr_reg[31:0];
					if (pwrite)
						r_next.level_thr_reg[31:0] = pwdata;
				end
				digital_gain_test_off: begin
					r_next.rdata = {16'h0, r_reg.level_thr_reg[39:32], r_reg.digital_gain_test_reg};
					if (pwrite) begin
						r_next.digital_gain_test_reg = pwdata[7:0];
						r_next.level_thr_reg[39:32] = pwdata[15:8];
					end
				end
				bandwidth_off: begin
					r_next.rdata = {16'h0, r_reg.bandwidth_reg};
					if (pwrite)
						r_next.bandwidth_reg = pwdata[15:0];
				end
				status_off: begin
					r_next.rdata = {20'h0, digital_gain, r_reg.signal_strength_value};
				end
				default: begin
					r_next.err = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg <= '0;
			r_reg.front_gain_control_reg <= front_gain_reset;
			r_reg.strength_threshold_reg <= threshold_reset;
			r_reg.control_reg <= control_reset;
			r_reg.level_thr_reg <= level_thr_reset;
			r_reg.digital_gain_test_reg <= digital_gain_stage_test_reset;
			r_reg.bandwidth_reg <= bandwidth_reset;
			r_reg.fsm <= st_idle;
			r_reg.gain <= 3'h1;
		end else begin
			r_reg <= r_next;
		end
	end

	// ----------------------------------------
	// digital gain stage, independent of data mode
	// ----------------------------------------
	digital_gain_stage u_dgs (
		.pclk         (pclk),
		.presetn      (presetn),
		.enable       (digital_gain_stage_on & r_reg.control_reg[rx_enable_pos]),
		.bit_tick     (tick_pulse),
		.level        (r_reg.signal_strength_value),
		.digital_gain (digital_gain)
	);

	logic [7:0] bw_q;
	logic [8:0] ref_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bw_q <= 8'h0;
			ref_q <= 9'h0;
		end else begin
			bw_q <= cur_bw;
			ref_q <= ref_level;
		end
	end

	assign prdata                 = r_reg.rdata;
	assign pready                 = r_reg.ready;
	assign pslverr                = r_reg.err;
	assign applied_gain_step      = r_reg.front_gain_control_reg[5:applied_lsb];
	assign input_impedance_select = r_reg.front_gain_control_reg[impedance_bit];
	assign active_bandwidth       = bw_q;
	assign reference_level_dbm    = ref_q;

endmodule

// file: receiver_gain_control_properties.sv
// port assertions for the receiver gain control block
module receiver_gain_control_checker
	import gain_control_pkg::*;
(
	// apb
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// analog and digital gain controls
	input wire logic [2:0]  applied_gain_step,
	input wire logic        input_impedance_select,
	input wire logic [3:0]  digital_gain
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic [2:0] want_step;
	logic       want_z;

	sequence take_s;
		psel && penable && !pready;
	endsequence
	sequence wr_gain_s;
		take_s ##0 (pwrite && paddr == front_gain_control_off);
	endsequence

	// ----
	// last value written to the gain register
	// ----
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			want_step <= 3'h1;
			want_z    <= 1'b0;
		end else if (psel && penable && !pready && pwrite && paddr == front_gain_control_off) begin
			want_step <= pwdata[2:0];
			want_z    <= pwdata[impedance_bit];
		end
	end

	AST_ANSWER_NEXT: assert property (take_s |=> pready) else $error("no answer one cycle after access");
	AST_READY_PULSE: assert property (pready |=> !pready) else $error("ready longer than one cycle");
	AST_UNMAPPED_ERR: assert property (take_s ##0 (paddr > status_off) |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	AST_MAPPED_OK: assert property (take_s ##0 (paddr <= status_off && paddr[1:0] == 2'h0) |=> !pslverr)
		else $error("mapped access refused");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready) else $error("error without ready");
	AST_STEP_RANGE: assert property (applied_gain_step inside {[3'h1:3'h6]}) else $error("gain step out of range");
	AST_FIXED_STEP: assert property (wr_gain_s ##0 (pwdata[2:0] inside {[3'h1:3'h6]}) |=> ##[0:8] applied_gain_step == want_step)
		else $error("forced gain step not applied");
	AST_IMPEDANCE: assert property (wr_gain_s |=> ##[0:4] input_impedance_select == want_z)
		else $error("impedance select not applied");
	AST_DGAIN_STEP: assert property ($changed(digital_gain) |-> (digital_gain == $past(digital_gain) + 4'h1 || digital_gain == $past(digital_gain) - 4'h1))
		else $error("digital gain jumped");
endmodule

bind receiver_gain_control receiver_gain_control_checker u_receiver_gain_control_checker (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.applied_gain_step, .input_impedance_select, .digital_gain
);

// file: test_receiver_gain_control.sv
// self-checking bench for the receiver gain control block
module test_receiver_gain_control;
	timeunit 1ns;
	timeprecision 1ps;
	import gain_control_pkg::*;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, tick_en;
	logic        adc_i_bit, adc_q_bit, bit_tick, fifo_empty, packet_done, input_impedance_select;
	logic [7:0]  paddr, active_bandwidth;
	logic [31:0] pwdata, prdata, q;
	logic [2:0]  applied_gain_step, s, tcnt;
	logic [3:0]  digital_gain;
	logic [8:0]  reference_level_dbm;
	int          errors, n_checks, cycles;

	receiver_gain_control u_receiver_gain_control (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .adc_i_bit, .adc_q_bit, .bit_tick, .fifo_empty, .packet_done,
		.applied_gain_step, .input_impedance_select, .active_bandwidth, .digital_gain, .reference_level_dbm);
	companion_host u_companion_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

	// ----
	// clock, bit ticks, timeout
	// ----
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (!presetn) begin
			tcnt     <= 3'h0;
			bit_tick <= 1'b0;
		end else begin
			tcnt     <= tcnt + 3'h1;
			bit_tick <= tick_en && tcnt == 3'h0;
		end
		cycles++;
		if (cycles == 20000) begin
			errors++;
			close_out();
		end
	end

	// ----
	// helpers
	// ----
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		n_checks++;
		if (g !== x) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_companion_host.xfer(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input string n);
		u_companion_host.xfer(1'b0, a, 32'h0, q, e);
		chk(n, x, q);
	endtask
	function automatic logic [31:0] exp_step(input logic [7:0] l);
		int n;
		n = 1;
		for (int k = 0; k < 5; k++) begin
			n += int'(l >= level_thr_reset[39 - 8*k -: 8]);
		end
		return 32'(n);
	endfunction
	task automatic check_auto(input string n);
		repeat (400) @(posedge pclk);
		u_companion_host.xfer(1'b0, status_off, 32'h0, q, e);
		chk(n, exp_step(q[7:0]), 32'(applied_gain_step));
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ----
	// scenarios
	// ----
	task automatic t_reset();
		chk("reset step", 32'h1, 32'(applied_gain_step));
		chk("reset dgain", 32'h8, 32'(digital_gain));
		rd(bandwidth_off, 32'(bandwidth_reset), "bandwidth reg");
		rd(front_gain_control_off, 32'h08, "gain reg");
		rd(strength_threshold_off, 32'he4, "threshold reg");
		rd(receive_control_off, 32'h1, "control reg");
		rd(gain_level_thr_off, 32'h60708090, "level thr reg");
		rd(digital_gain_test_off, 32'h5030, "digital_gain_stage reg");
		rd(8'h1c, 32'h0, "unmapped data");
		chk("unmapped err", 32'h1, 32'(e));
	endtask
	task automatic t_agc();
		wr(digital_gain_test_off, 32'h5030);
		wr(strength_threshold_off, 32'hff);
		wr(receive_control_off, 32'h19);
		tick_en <= 1'b1;
		repeat (400) @(posedge pclk);
		chk("waiting step", 32'h1, 32'(applied_gain_step));
		chk("correction bw", 32'(bandwidth_reset[15:8]), 32'(active_bandwidth));
		chk("digital gain floor", 32'h0, 32'(digital_gain));
		wr(strength_threshold_off, 32'h0);
		check_auto("acquired step");
	endtask
	task automatic t_hold();
		s = applied_gain_step;
		adc_i_bit   <= 1'b0;
		packet_done <= 1'b1;
		fifo_empty  <= 1'b1;
		repeat (400) @(posedge pclk);
		chk("held step", 32'(s), 32'(applied_gain_step));
		chk("channel bw", 32'(bandwidth_reset[7:0]), 32'(active_bandwidth));
		rd(front_gain_control_off, {26'h0, s, 3'h0}, "applied field");
	endtask
	task automatic t_restart();
		wr(receive_control_off, 32'h0d);
		check_auto("restart step");
	endtask
	task automatic t_auto();
		s = applied_gain_step;
		adc_i_bit <= 1'b1;
		wr(receive_control_off, 32'h010b);
		repeat (60) @(posedge pclk);
		chk("delayed step", 32'(s), 32'(applied_gain_step));
		check_auto("auto restart step");
	endtask
	task automatic t_reference();
		logic [8:0] base;
		base = reference_level_dbm;
		wr(bandwidth_off, {16'h0, bandwidth_reset + 16'h1});
		repeat (4) @(posedge pclk);
		chk("reference step", 32'(base - 9'h3), 32'(reference_level_dbm));
		rd(bandwidth_off, {16'h0, bandwidth_reset + 16'h1}, "bandwidth reg");
	endtask
	task automatic t_fixed();
		for (int i = 1; i <= 6; i++) begin
			s = 3'(i);
			wr(front_gain_control_off, {24'h0, s[0], 4'h0, s});
			repeat (4) @(posedge pclk);
			chk("forced step", 32'(s), 32'(applied_gain_step));
			chk("impedance", 32'(s[0]), 32'(input_impedance_select));
			rd(front_gain_control_off, {24'h0, s[0], 1'b0, s, s}, "forced field");
		end
	endtask

	initial begin
		presetn     = 1'b0;
		tick_en     = 1'b0;
		adc_i_bit   = 1'b1;
		adc_q_bit   = 1'b1;
		fifo_empty  = 1'b0;
		packet_done = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_agc();
		t_hold();
		t_restart();
		t_auto();
		t_fixed();
		t_reference();
		close_out();
	end
endmodule
